// *** hbw_pkg.sv ***
// shared constants and carrier types for the blanking h-clock width block
package hbw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] WIDTH_REG_ADDR  = 8'h35;
  localparam int         WIDTH_LSB       = 4;
  localparam int         WIDTH_MSB       = 6;
  localparam logic [2:0] WIDTH_RESET     = 3'h0;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // ----------------------------------------------------------------
  // counter widths and reset values
  // ----------------------------------------------------------------
  localparam int         PIX_W           = 13;
  localparam int         LINE_W          = 12;
  localparam int         CODE_W          = 3;
  localparam logic [2:0] DIV_COUNT_RESET = 3'h0;
  localparam logic [2:0] CODE_FULL_RATE  = 3'h0;
  localparam logic [12:0] LINE_START_PIX = 13'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [7:0]       addr;
    logic [7:0]       wdata;
  } hbw_reg_req_t;

  // timing of the vertical sequence that is active right now
  typedef struct packed {
    logic [PIX_W-1:0] blank_tog1;
    logic [PIX_W-1:0] blank_tog2;
    logic             blank_polarity;
    logic             clamp_pol;
    logic [PIX_W-1:0] clamp_tog1;
    logic [PIX_W-1:0] clamp_tog2;
    logic             preblank_pol;
    logic [PIX_W-1:0] preblank_tog1;
    logic [PIX_W-1:0] preblank_tog2;
  } hbw_seq_t;

  typedef struct packed {
    logic              enable;
    logic [LINE_W-1:0] first_line;
    logic [LINE_W-1:0] last_line;
  } hbw_clamp_mask_t;

  typedef struct packed {
    logic one;
    logic two;
    logic three;
    logic four;
  } hbw_phase_t;

  typedef enum logic [1:0] {
    HBW_ACTIVE = 2'b00,
    HBW_HOLD   = 2'b01,
    HBW_DIV    = 2'b10,
    HBW_FULL   = 2'b11
  } hbw_hmode_t;

endpackage

// *** hbw_hclk_div.sv ***
// programmable even divider for the widened blanking h-clock
`timescale 1ns/1ps
module hbw_hclk_div
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       restart,
  input  wire logic [2:0] ratio_code,
  output logic            div_level
);

  logic [2:0] count;
  logic [2:0] next_count;
  logic       next_level;

  // ----------------------------------------------------------------
  // half period is ratio_code pixels, so full period is 2*code
  // ----------------------------------------------------------------
  always_comb
  begin
    next_count = count;
    next_level = div_level;
    if (restart)
    begin
      // restart keeps the first wide pulse aligned to blank start
      next_count = hbw_pkg::DIV_COUNT_RESET;
      next_level = 1'b1;
    end
    else if (count + 3'h1 >= ratio_code)
    begin
      next_count = hbw_pkg::DIV_COUNT_RESET;
      next_level = ~div_level;
    end
    else
    begin
      next_count = count + 3'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      count     <= hbw_pkg::DIV_COUNT_RESET;
      div_level <= 1'b1;
    end
    else
    begin
      count     <= next_count;
      div_level <= next_level;
    end
  end

endmodule

// *** hbw_core.sv ***
// blanking h-clock width control with clamp and preblank generation
`timescale 1ns/1ps
// What this block does
// - width code held at 0x35 bits 6:4
// - codes 1..7 divide by 2..14
// - code zero keeps full pixel rate
// - reduced rate only inside blanking
// - timing taken from active vertical sequence
// - clamp suppressed inside mask line range
// - optional preblank output provided
// - polarity high: phases 1,3 high, 2,4 low
// - blanking toggles at two programmed pixels
module hbw_core
(
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire hbw_pkg::hbw_reg_req_t    reg_req,
  output logic [7:0]                    reg_rdata,
  input  wire hbw_pkg::hbw_seq_t        seq_cfg,
  input  wire hbw_pkg::hbw_clamp_mask_t clamp_mask,
  input  wire logic [12:0]              pixel_pos,
  input  wire logic [11:0]              line_num,
  input  wire logic                     hclock_pixel_rate,
  output hbw_pkg::hbw_phase_t           hclock_phase,
  output logic                          horizontal_blanking,
  output logic                          optical_black_clamp,
  output logic                          output_preblank
);

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [2:0] blanking_hclock_width_select;
  logic [2:0] next_width;
  logic [7:0] next_rdata;

  always_comb
  begin
    next_width = blanking_hclock_width_select;
    next_rdata = reg_rdata;
    if (reg_req.wr && reg_req.addr == hbw_pkg::WIDTH_REG_ADDR)
    begin
      next_width = reg_req.wdata[hbw_pkg::WIDTH_MSB:hbw_pkg::WIDTH_LSB];
    end
    if (reg_req.rd)
    begin
      if (reg_req.addr == hbw_pkg::WIDTH_REG_ADDR)
      begin
        next_rdata = {1'b0, blanking_hclock_width_select, 4'h0};
      end
      else
      begin
        next_rdata = hbw_pkg::READ_ZERO;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      blanking_hclock_width_select <= hbw_pkg::WIDTH_RESET;
      reg_rdata                    <= hbw_pkg::READ_ZERO;
    end
    else
    begin
      blanking_hclock_width_select <= next_width;
      reg_rdata                    <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // toggle-position pulses
  // ----------------------------------------------------------------
  // each pulse restarts at line start from its start level, then flips at
  // its two toggle pixels; blanking has no start level of its own
  logic blank_state;
  logic clamp_state;
  logic preblank_state;
  logic next_blank;
  logic next_clamp;
  logic next_preblank;
  logic line_start;
  logic in_mask;

  assign line_start = (pixel_pos == hbw_pkg::LINE_START_PIX);
  assign in_mask    = clamp_mask.enable &&
                      line_num >= clamp_mask.first_line &&
                      line_num <= clamp_mask.last_line;

  always_comb
  begin
    next_blank    = line_start ? 1'b0 : blank_state;
    next_clamp    = line_start ? seq_cfg.clamp_pol : clamp_state;
    next_preblank = line_start ? seq_cfg.preblank_pol : preblank_state;
    if (pixel_pos == seq_cfg.blank_tog1 || pixel_pos == seq_cfg.blank_tog2)
    begin
      next_blank = ~next_blank;
    end
    if (pixel_pos == seq_cfg.clamp_tog1 || pixel_pos == seq_cfg.clamp_tog2)
    begin
      next_clamp = ~next_clamp;
    end
    if (pixel_pos == seq_cfg.preblank_tog1 || pixel_pos == seq_cfg.preblank_tog2)
    begin
      next_preblank = ~next_preblank;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      blank_state    <= 1'b0;
      clamp_state    <= 1'b0;
      preblank_state <= 1'b0;
    end
    else
    begin
      blank_state    <= next_blank;
      clamp_state    <= next_clamp;
      preblank_state <= next_preblank;
    end
  end

  // ----------------------------------------------------------------
  // h-clock divider and phase selection
  // ----------------------------------------------------------------
  logic                div_level;
  logic                blank_rise;
  hbw_pkg::hbw_hmode_t hmode;
  logic                next_h_level;
  logic                h_level;
  logic                next_hb_out;
  logic                next_clamp_out;

  assign blank_rise = next_blank && !blank_state;

  hbw_hclk_div u_div
  (
    .clk        (clk),
    .srst       (srst),
    .restart    (blank_rise),
    .ratio_code (blanking_hclock_width_select),
    .div_level  (div_level)
  );

  always_comb
  begin
    if (!blank_state)
    begin
      hmode = hbw_pkg::HBW_ACTIVE;
    end
    else if (seq_cfg.blank_polarity)
    begin
      hmode = hbw_pkg::HBW_HOLD;
    end
    else if (blanking_hclock_width_select == hbw_pkg::CODE_FULL_RATE)
    begin
      hmode = hbw_pkg::HBW_FULL;
    end
    else
    begin
      hmode = hbw_pkg::HBW_DIV;
    end
    case (hmode)
      hbw_pkg::HBW_HOLD: next_h_level = 1'b1;
      hbw_pkg::HBW_DIV:  next_h_level = div_level;
      default:           next_h_level = hclock_pixel_rate;
    endcase
    next_hb_out    = blank_state;
    // mask only gates the pin; clamp sequence state runs on untouched
    next_clamp_out = clamp_state && !in_mask;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      h_level             <= 1'b1;
      horizontal_blanking <= 1'b0;
      optical_black_clamp <= 1'b0;
      output_preblank     <= 1'b0;
    end
    else
    begin
      h_level             <= next_h_level;
      horizontal_blanking <= next_hb_out;
      optical_black_clamp <= next_clamp_out;
      output_preblank     <= preblank_state;
    end
  end

  // phases one/three follow the level, two/four are its complement
  assign hclock_phase = '{one: h_level, two: ~h_level, three: h_level, four: ~h_level};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  width_write_a : assert property (@(posedge clk) disable iff (srst)
    (reg_req.wr && reg_req.addr == hbw_pkg::WIDTH_REG_ADDR)
    |=> blanking_hclock_width_select
        == $past(reg_req.wdata[hbw_pkg::WIDTH_MSB:hbw_pkg::WIDTH_LSB]))
    else $error("width select not stored");

  width_read_a : assert property (@(posedge clk) disable iff (srst)
    (reg_req.rd && reg_req.addr != hbw_pkg::WIDTH_REG_ADDR) |=> reg_rdata == hbw_pkg::READ_ZERO)
    else $error("unmapped read not zero");

  hold_level_a : assert property (@(posedge clk) disable iff (srst)
    (blank_state && seq_cfg.blank_polarity) |=> (hclock_phase.one && !hclock_phase.two))
    else $error("blank polarity hold wrong");

  full_rate_a : assert property (@(posedge clk) disable iff (srst)
    (!blank_state) |=> h_level == $past(hclock_pixel_rate))
    else $error("active region not at pixel rate");

  code_zero_a : assert property (@(posedge clk) disable iff (srst)
    (blank_state && !seq_cfg.blank_polarity
     && blanking_hclock_width_select == hbw_pkg::CODE_FULL_RATE)
    |=> h_level == $past(hclock_pixel_rate))
    else $error("code zero not at pixel rate");

  div_restart_a : assert property (@(posedge clk) disable iff (srst)
    blank_rise |=> div_level)
    else $error("divider not restarted");

  div_half_a : assert property (@(posedge clk) disable iff (srst)
    (blanking_hclock_width_select == 3'h2 && $stable(blanking_hclock_width_select)
     && !blank_rise && $changed(div_level))
    |=> (!blank_rise && $stable(blanking_hclock_width_select)) |-> $stable(div_level))
    else $error("divide by four half period wrong");

  clamp_mask_a : assert property (@(posedge clk) disable iff (srst)
    in_mask |=> !optical_black_clamp)
    else $error("clamp not masked");

  blank_toggle_a : assert property (@(posedge clk) disable iff (srst)
    (pixel_pos == seq_cfg.blank_tog1 && pixel_pos != seq_cfg.blank_tog2 && !line_start)
    |=> blank_state != $past(blank_state))
    else $error("blanking did not toggle");

  preblank_a : assert property (@(posedge clk) disable iff (srst)
    (pixel_pos == seq_cfg.preblank_tog1 && pixel_pos != seq_cfg.preblank_tog2 && !line_start)
    |=> ##1 output_preblank != $past(output_preblank))
    else $error("preblank out of step");

  cover_div_c   : cover property (@(posedge clk) disable iff (srst)
    hmode == hbw_pkg::HBW_DIV ##1 $changed(div_level));
  cover_hold_c  : cover property (@(posedge clk) disable iff (srst) hmode == hbw_pkg::HBW_HOLD);
  cover_mask_c  : cover property (@(posedge clk) disable iff (srst) in_mask && clamp_state);
  cover_blank_c : cover property (@(posedge clk) disable iff (srst) blank_rise);

endmodule

// *** hbw_ccd_model.sv ***
// horizontal register model of the sensor, measuring the shift clock period
`timescale 1ns/1ps
module hbw_ccd_model
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire hbw_pkg::hbw_phase_t  hclock_phase,
  output logic [7:0]                shift_period
);
  // ----------------------------------------------------------------
  // charge moves one cell per rise of phase one
  // ----------------------------------------------------------------
  logic       prev_one;
  logic [7:0] run;

  // period is cycles between two rises, so the bench sees width directly
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      prev_one     <= 1'b0;
      run          <= 8'h00;
      shift_period <= 8'h00;
    end
    else
    begin
      prev_one <= hclock_phase.one;
      if (hclock_phase.one && !prev_one)
      begin
        shift_period <= run;
        run          <= 8'h01;
      end
      else if (run != 8'hFF)
      begin
        run <= run + 8'h01;
      end
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the blanking h-clock width block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module testbench;
  // ----------------------------------------------------------------
  // stimulus and design
  // ----------------------------------------------------------------
  logic                     clk;
  logic                     srst;
  hbw_pkg::hbw_reg_req_t    reg_req;
  logic [7:0]               reg_rdata;
  hbw_pkg::hbw_seq_t        seq_cfg;
  hbw_pkg::hbw_clamp_mask_t clamp_mask;
  logic [12:0]              pixel_pos;
  logic [11:0]              line_num;
  logic                     hclock_pixel_rate;
  hbw_pkg::hbw_phase_t      hclock_phase;
  logic                     horizontal_blanking;
  logic                     optical_black_clamp;
  logic                     output_preblank;
  logic [7:0]               shift_period;
  logic [7:0]               rd;
  int                       num_errors;
  int                       tests_run;
  int                       cycles;

  hbw_core i_dut
  (
    .clk                 (clk),
    .srst                (srst),
    .reg_req             (reg_req),
    .reg_rdata           (reg_rdata),
    .seq_cfg             (seq_cfg),
    .clamp_mask          (clamp_mask),
    .pixel_pos           (pixel_pos),
    .line_num            (line_num),
    .hclock_pixel_rate   (hclock_pixel_rate),
    .hclock_phase        (hclock_phase),
    .horizontal_blanking (horizontal_blanking),
    .optical_black_clamp (optical_black_clamp),
    .output_preblank     (output_preblank)
  );

  hbw_ccd_model i_ccd
  (
    .clk          (clk),
    .srst         (srst),
    .hclock_phase (hclock_phase),
    .shift_period (shift_period)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // short 200-pixel lines keep the run brief; pixel rate toggles each cycle
  always @(posedge clk)
  begin
    pixel_pos         <= (pixel_pos == 13'h00C7) ? 13'h0000 : pixel_pos + 13'h0001;
    line_num          <= (pixel_pos == 13'h00C7) ? line_num + 12'h001 : line_num;
    hclock_pixel_rate <= ~hclock_pixel_rate;
    cycles++;
    if (cycles == 30000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  end
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
    #1 d = reg_rdata;
  end
  endtask

  task automatic at_pix(input int p);
  begin
    do @(posedge clk); while (pixel_pos != 13'(p));
    #1;
  end
  endtask

  task automatic wrap_up();
  begin
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1; reg_req = '0; clamp_mask = '0; pixel_pos = '0; line_num = '0;
    hclock_pixel_rate = 1'b0; num_errors = 0; tests_run = 0; cycles = 0;
    seq_cfg = '0;
    seq_cfg.blank_tog1 = 13'h000A; seq_cfg.blank_tog2 = 13'h006E;
    seq_cfg.clamp_tog1 = 13'h0078; seq_cfg.clamp_tog2 = 13'h00AA;
    seq_cfg.preblank_pol = 1'b1;
    seq_cfg.preblank_tog1 = 13'h0005; seq_cfg.preblank_tog2 = 13'h001E;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    reg_rd(8'h35, rd); `CHK("width reset", 8'h00, rd)
    reg_wr(8'h35, 8'hFF);
    reg_wr(8'h34, 8'h00);
    reg_rd(8'h35, rd); `CHK("width field", 8'h70, rd)
    reg_rd(8'h12, rd); `CHK("unmapped read", 8'h00, rd)
    at_pix(199); at_pix(15);
    `CHK("restart high", 1'b1, hclock_phase.one)
    at_pix(20); `CHK("restart low", 1'b0, hclock_phase.one)
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(8'h35, 8'(c << 4));
      at_pix(199); at_pix(90);
      `CHK("blank period", (c == 0) ? 2 : 2 * c, shift_period)
      `CHK("blank on", 1'b1, horizontal_blanking)
      at_pix(195);
      `CHK("line period", 2, shift_period)
      `CHK("blank off", 1'b0, horizontal_blanking)
    end
    at_pix(150); `CHK("clamp on", 1'b1, optical_black_clamp)
    at_pix(15); `CHK("preblank off", 1'b0, output_preblank)
    at_pix(60); `CHK("preblank on", 1'b1, output_preblank)
    @(posedge clk);
    clamp_mask <= '{enable: 1'b1, first_line: 12'h000, last_line: 12'hFFF};
    seq_cfg.blank_polarity <= 1'b1;
    at_pix(199); at_pix(60);
    `CHK("held phases", 4'b1010, hclock_phase)
    at_pix(150); `CHK("clamp masked", 1'b0, optical_black_clamp)
    @(posedge clk);
    seq_cfg.blank_tog1 <= 13'h0028;
    seq_cfg.blank_tog2 <= 13'h003C;
    seq_cfg.clamp_pol  <= 1'b1;
    clamp_mask.enable  <= 1'b0;
    at_pix(199); at_pix(50);
    `CHK("new blank on", 1'b1, horizontal_blanking)
    at_pix(90);
    `CHK("new sequence", 1'b0, horizontal_blanking)
    `CHK("clamp start level", 1'b1, optical_black_clamp)
    wrap_up();
  end
endmodule
